/* File: rtl/i2c_line_sync.sv */
// Two-flop synchroniser with edge and condition detection for SCL and SDA
`timescale 1ns/1ps
`default_nettype none

module i2c_line_sync
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // Raw bus lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Conditioned events
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      start_out,
  output logic      stop_out,
  output logic      sda_out
);

  logic [1:0] scl_meta_reg;
  logic [1:0] sda_meta_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
    end
    else
    begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_meta_reg[1];
      sda_prev_reg <= sda_meta_reg[1];
    end
  end

  assign scl_rise_out = scl_meta_reg[1] & ~scl_prev_reg;
  assign scl_fall_out = ~scl_meta_reg[1] & scl_prev_reg;
  // Conditions need SCL high on both samples
  assign start_out = scl_meta_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_meta_reg[1];
  assign stop_out  = scl_meta_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_meta_reg[1];
  assign sda_out   = sda_meta_reg[1];

endmodule

`default_nettype wire

/* File: rtl/i2c_regacc_pkg.sv */
// Types for the I2C register access slave
`default_nettype none

package i2c_regacc_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX   = 6'h04,
    ST_TX   = 6'h08,
    ST_ACK  = 6'h10,
    ST_MACK = 6'h20
  } slave_state_t;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

`default_nettype wire

/* File: rtl/i2c_regacc_regs.svh */
// Constants for the I2C register access slave
`ifndef I2C_REGACC_REGS_SVH
`define I2C_REGACC_REGS_SVH

`define I2C_DEV_ADDR          7'h51
`define I2C_ADDR_BYTE_WR      8'ha2
`define I2C_ADDR_BYTE_RD      8'ha3
`define I2C_PTR_RESET         8'h00
`define I2C_READ_BLANK        8'hff
`define I2C_CLK_FREQ_HZ       100000000
`define I2C_TIMEOUT_S         1
`define I2C_TIMEOUT_CYCLES    (`I2C_TIMEOUT_S * `I2C_CLK_FREQ_HZ)

`endif

/* File: rtl/i2c_regacc_slave.sv */
// I2C slave giving byte access to internal registers through a pointer
//
// Functional notes
// - Answer only bus address 1010001b, acknowledging it for both directions.
// - Other addresses: ignore the transfer, SDA stays released at acknowledge.
// - Address byte MSB first; last bit 1 reads (A3h), 0 writes (A2h).
// - Addressed as receiver, acknowledge every received byte in ninth clock.
// - Acknowledger holds SDA low through the whole ninth clock high phase.
// - On no acknowledge, release SDA so the master can STOP.
// - First written byte after the address loads the 8-bit pointer.
// - Pointer increments by one after each written data byte.
// - Write: START, A2h, ack, pointer, ack, data bytes acked, STOP.
// - A write ends on STOP or on the next START.
// - Random read: write pointer, repeated START or STOP+START, then A3h.
// - Reading sends the pointed register, incrementing for each byte sent, acked or not.
// - Read straight after START sends from last accessed address plus one.
// - Any number of data bytes is accepted in one transfer.
// - SCL is only sampled, never driven; SDA is bidirectional.
// - After one second in a transfer, go idle, drop writes, read FFh.
// - Repeated START behaves as STOP followed by START.
`timescale 1ns/1ps
`default_nettype none

`include "i2c_regacc_regs.svh"

module i2c_regacc_slave
#(
  parameter int unsigned TIMEOUT_CYCLES = `I2C_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  // Bus pins
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_out,
  // Register file port
  output i2c_regacc_pkg::reg_req_t      reg_req_out,
  input  wire logic [7:0]               reg_rdata_in,
  // Status
  output logic                          busy_out,
  output logic                          timeout_out
);

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_s;

  i2c_line_sync u_sync
  (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_det),
    .stop_out     (stop_det),
    .sda_out      (sda_s)
  );

  i2c_regacc_pkg::slave_state_t state_reg;
  logic [7:0]                   shift_reg;
  logic [3:0]                   bit_cnt_reg;
  logic                         read_mode_reg;
  logic                         ptr_loaded_reg;
  logic                         ack_pending_reg;
  logic [7:0]                   ptr_reg;
  logic                         dead_reg;
  logic [31:0]                  tmo_cnt_reg;
  logic                         in_xfer_reg;
  logic [7:0]                   rx_byte;
  logic                         tmo_hit;

  assign rx_byte = {shift_reg[6:0], sda_s};
  assign tmo_hit = in_xfer_reg && (tmo_cnt_reg >= TIMEOUT_CYCLES - 32'h1);

  // Transfer timer, running from START until STOP or timeout
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      in_xfer_reg <= 1'b0;
      tmo_cnt_reg <= 32'h0;
    end
    else if (start_det)
    begin
      in_xfer_reg <= 1'b1;
      tmo_cnt_reg <= 32'h0;
    end
    else if (stop_det || tmo_hit)
    begin
      in_xfer_reg <= 1'b0;
      tmo_cnt_reg <= 32'h0;
    end
    else if (in_xfer_reg)
    begin
      tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
    end
  end

  // Timed-out flag holds until the next START
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dead_reg <= 1'b0;
    end
    else if (start_det)
    begin
      dead_reg <= 1'b0;
    end
    else if (tmo_hit)
    begin
      dead_reg <= 1'b1;
    end
  end

  // Byte-level state machine
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg       <= i2c_regacc_pkg::ST_IDLE;
      shift_reg       <= 8'h00;
      bit_cnt_reg     <= 4'h0;
      read_mode_reg   <= 1'b0;
      ptr_loaded_reg  <= 1'b0;
      ack_pending_reg <= 1'b0;
    end
    else if (start_det)
    begin
      // Repeated START restarts address phase
      state_reg      <= i2c_regacc_pkg::ST_ADDR;
      bit_cnt_reg    <= 4'h0;
      ptr_loaded_reg <= 1'b0;
      read_mode_reg  <= 1'b0;
    end
    else if (stop_det || tmo_hit)
    begin
      state_reg <= i2c_regacc_pkg::ST_IDLE;
    end
    else
    begin
      case (state_reg)
        i2c_regacc_pkg::ST_ADDR,
        i2c_regacc_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == i2c_regacc_pkg::ST_ADDR)
            begin
              if (shift_reg[7:1] == `I2C_DEV_ADDR)
              begin
                read_mode_reg <= shift_reg[0];
                state_reg     <= i2c_regacc_pkg::ST_ACK;
              end
              else
              begin
                state_reg <= i2c_regacc_pkg::ST_IDLE;
              end
            end
            else
            begin
              ptr_loaded_reg <= 1'b1;
              state_reg      <= i2c_regacc_pkg::ST_ACK;
            end
          end
        end
        i2c_regacc_pkg::ST_ACK:
        begin
          // Ack driven across the ninth clock, released on its falling edge
          if (scl_fall)
          begin
            state_reg <= read_mode_reg ? i2c_regacc_pkg::ST_TX
                                       : i2c_regacc_pkg::ST_RX;
          end
        end
        i2c_regacc_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7)
            begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= i2c_regacc_pkg::ST_MACK;
            end
          end
        end
        i2c_regacc_pkg::ST_MACK:
        begin
          if (scl_rise)
          begin
            ack_pending_reg <= ~sda_s;
          end
          else if (scl_fall)
          begin
            // No acknowledge: stay released until STOP
            state_reg <= ack_pending_reg ? i2c_regacc_pkg::ST_TX
                                         : i2c_regacc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // Register pointer and register writes
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ptr_reg     <= `I2C_PTR_RESET;
      reg_req_out <= '0;
    end
    else
    begin
      reg_req_out.wr_en <= 1'b0;
      if (!start_det && !stop_det && !tmo_hit && !dead_reg && scl_fall)
      begin
        if (state_reg == i2c_regacc_pkg::ST_RX && bit_cnt_reg == 4'h8)
        begin
          if (!ptr_loaded_reg)
          begin
            ptr_reg <= shift_reg;
          end
          else
          begin
            reg_req_out.wr_en <= 1'b1;
            reg_req_out.addr  <= ptr_reg;
            reg_req_out.wdata <= shift_reg;
            ptr_reg           <= ptr_reg + 8'h01;
          end
        end
        else if (state_reg == i2c_regacc_pkg::ST_MACK)
        begin
          // Every sent byte advances, so a later read resumes one past it
          ptr_reg <= ptr_reg + 8'h01;
        end
      end
      if (!reg_req_out.wr_en)
      begin
        reg_req_out.addr <= ptr_reg;
      end
    end
  end

  // SDA drive; SCL has no driver at all
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sda_oe_out <= 1'b0;
    end
    else if (start_det || stop_det || tmo_hit || dead_reg)
    begin
      sda_oe_out <= 1'b0;
    end
    else if (state_reg == i2c_regacc_pkg::ST_ACK)
    begin
      sda_oe_out <= 1'b1;
    end
    else if (state_reg == i2c_regacc_pkg::ST_TX)
    begin
      // Open drain: drive only the zero bits
      sda_oe_out <= ~(reg_rdata_in[3'h7 - bit_cnt_reg[2:0]]);
    end
    else
    begin
      sda_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sda_out     <= 1'b0;
      busy_out    <= 1'b0;
      timeout_out <= 1'b0;
    end
    else
    begin
      sda_out     <= 1'b0;
      busy_out    <= in_xfer_reg;
      timeout_out <= dead_reg;
    end
  end

endmodule

`default_nettype wire

/* File: sim/i2c_master_model.sv */
// Bus master model driving SCL and the open-drain SDA
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
  // Bench clock and bus lines
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic start;
    sda_drv_out <= 1'b1;
    // Slave lets go of SDA four clocks after the SCL fall
    repeat (6) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    sda_drv_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
  task automatic stop;
    repeat (2) @(posedge clk_in);
    sda_drv_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    sda_drv_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  // Data moves only while SCL is low
  // SCL period 80 ns: 60 ns low covers the slave's sync latency
  task automatic bit_xfer(input logic b, output logic r);
    repeat (2) @(posedge clk_in);
    sda_drv_out <= b;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], r);
    bit_xfer(1'b1, ack_n);
  endtask
  task automatic rd_byte(input logic ack_n, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      b[i] = r;
    end
    bit_xfer(ack_n, r);
  endtask
endmodule
`default_nettype wire

/* File: sim/i2c_regacc_monitor.sv */
// Port checks for the I2C register access slave
`timescale 1ns/1ps
`default_nettype none
module i2c_regacc_monitor
#(
  parameter int unsigned TIMEOUT_CYCLES = 100
)
(
  // Watched ports
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  input  wire logic                     sda_out,
  input  wire logic                     sda_oe_out,
  input  wire i2c_regacc_pkg::reg_req_t reg_req_out,
  input  wire logic                     busy_out,
  input  wire logic                     timeout_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  property p_oe_scl_low;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  property p_idle_free;
    !busy_out && !$past(busy_out) |-> !sda_oe_out;
  endproperty
  property p_tout_free;
    timeout_out && $past(timeout_out) |-> !sda_oe_out;
  endproperty
  property p_wr_pulse;
    reg_req_out.wr_en |=> !reg_req_out.wr_en;
  endproperty
  property p_wr_live;
    reg_req_out.wr_en |-> busy_out && !timeout_out;
  endproperty
  property p_start_busy;
    s_start |-> ##[2:6] (busy_out && !timeout_out);
  endproperty
  property p_stop_idle;
    s_stop |-> ##[2:6] !busy_out;
  endproperty
  property p_tout_cause;
    $rose(timeout_out) |-> $past(busy_out);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda value high");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
  a_idle_free: assert property (p_idle_free) else $error("sda held idle");
  a_tout_free: assert property (p_tout_free) else $error("sda held in timeout");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long");
  a_wr_live: assert property (p_wr_live) else $error("write outside transfer");
  a_start_busy: assert property (p_start_busy) else $error("start missed");
  a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
  a_tout_cause: assert property (p_tout_cause) else $error("timeout when idle");
endmodule
bind i2c_regacc_slave i2c_regacc_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (
  .sys_clk_in (sys_clk_in),
  .rst_n_in   (rst_n_in),
  .scl_in     (scl_in),
  .sda_in     (sda_in),
  .sda_out    (sda_out),
  .sda_oe_out (sda_oe_out),
  .reg_req_out(reg_req_out),
  .busy_out   (busy_out),
  .timeout_out(timeout_out)
);
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the I2C register access slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TOUT = 2000;
  logic                     sys_clk_in;
  logic                     rst_n_in;
  logic                     scl;
  logic                     drv;
  wire logic                sda;
  logic                     oe;
  logic                     sda_o;
  i2c_regacc_pkg::reg_req_t req;
  logic [7:0]               rdata;
  logic                     busy;
  logic                     tout;
  logic [7:0]               mem [256];
  int                       err_count;
  int                       total_checks;
  logic                     a;
  logic [7:0]               d;
  assign sda = drv & ~(oe & ~sda_o);
  assign rdata = mem[req.addr];
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
    if (req.wr_en === 1'b1)
      mem[req.addr] <= req.wdata;
  i2c_regacc_slave #(.TIMEOUT_CYCLES(TOUT)) dut (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .scl_in      (scl),
    .sda_in      (sda),
    .sda_out     (sda_o),
    .sda_oe_out  (oe),
    .reg_req_out (req),
    .reg_rdata_in(rdata),
    .busy_out    (busy),
    .timeout_out (tout)
  );
  i2c_master_model m (
    .clk_in     (sys_clk_in),
    .sda_in     (sda),
    .scl_out    (scl),
    .sda_drv_out(drv)
  );
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic exp_n);
    m.wr_byte(b, a);
    chk("ack", {7'h0, a}, {7'h0, exp_n});
  endtask
  task automatic t_write;
    m.start();
    chk("busy set", {7'h0, busy}, 8'h01);
    wb(8'ha2, 1'b0);
    wb(8'h10, 1'b0);
    for (int i = 0; i < 4; i++)
      wb(8'hc0 + 8'(i), 1'b0);
    m.stop();
    for (int i = 0; i < 4; i++)
      chk("mem", mem[8'h10 + i], 8'hc0 + 8'(i));
    chk("busy", {7'h0, busy}, 8'h00);
    $display("test write done");
  endtask
  task automatic t_rand_read;
    m.start();
    wb(8'ha2, 1'b0);
    wb(8'h11, 1'b0);
    m.start();
    wb(8'ha3, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      m.rd_byte(i == 2, d);
      chk("rd", d, 8'hc1 + 8'(i));
    end
    m.stop();
    $display("test random read done");
  endtask
  task automatic t_cur_read;
    m.start();
    wb(8'ha3, 1'b0);
    m.rd_byte(1'b1, d);
    chk("next rd", d, 8'h14 ^ 8'h5a);
    m.stop();
    m.start();
    wb(8'ha2, 1'b0);
    wb(8'h20, 1'b0);
    wb(8'h77, 1'b0);
    m.stop();
    m.start();
    wb(8'ha3, 1'b0);
    m.rd_byte(1'b1, d);
    chk("cur rd", d, 8'h21 ^ 8'h5a);
    m.stop();
    $display("test current read done");
  endtask
  task automatic t_bad_addr;
    logic [7:0] bad [3] = '{8'ha0, 8'ha4, 8'h23};
    for (int i = 0; i < 3; i++)
    begin
      m.start();
      wb(bad[i], 1'b1);
      wb(8'h00, 1'b1);
      m.stop();
    end
    $display("test bad address done");
  endtask
  task automatic t_timeout;
    m.start();
    wb(8'ha2, 1'b0);
    wb(8'h30, 1'b0);
    repeat (TOUT + 100) @(posedge sys_clk_in);
    chk("tout", {7'h0, tout}, 8'h01);
    wb(8'h99, 1'b1);
    m.start();
    chk("tout clr", {7'h0, tout}, 8'h00);
    wb(8'ha3, 1'b0);
    repeat (TOUT + 100) @(posedge sys_clk_in);
    m.rd_byte(1'b1, d);
    chk("blank rd", d, 8'hff);
    m.stop();
    chk("drop wr", mem[8'h30], 8'h30 ^ 8'h5a);
    $display("test timeout done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    rst_n_in = 1'b0;
    err_count = 0;
    total_checks = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_write();
    t_rand_read();
    t_cur_read();
    t_bad_addr();
    t_timeout();
    end_sim();
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk_in);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
